/* inc/tfs_pkg.sv */
// Purpose: Shared constants and types for the thermal fault supervisor
// Assumes: 100 MHz sys_clk
// Notes: Comparator flags arrive from analog front end per channel
`default_nettype none
package tfs_pkg;
  // ==========================================
  // Timing
  localparam int SYS_CLK_MHZ = 100;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS * SYS_CLK_MHZ / 1000;
  localparam int FAULT_TIME_US = 100;
  localparam int FAULT_TICKS = FAULT_TIME_US * 1000 / TICK_NS;
  localparam int CNT_W = 8;
  localparam int DIV_W = 8;
  localparam int NUM_CH = 2;
  localparam int CH_CORE = 0;
  localparam int CH_NB = 1;
  // Thresholds held by the analog comparators, recorded for reference
  localparam int WARN_MV = 640;
  localparam int HYST_MV = 20;
  localparam int SHDN_MV = 580;

  // ==========================================
  // Types
  typedef struct packed {
    logic warn;   // Input at or below warning trip level
    logic rst_ok; // Input above reset level (trip plus hysteresis)
    logic shdn;   // Input at or below shutdown level
  } tfs_flags_s;

  typedef enum logic [1:0] {
    TFS_OFF = 2'b00,
    TFS_RUN = 2'b01,
    TFS_FAULT = 2'b10
  } tfs_state_e;
endpackage : tfs_pkg
`default_nettype wire

/* hw/tfs_supervisor.sv */
// Purpose: Thermal alert, up/down fault counter and latched shutdown
// Assumes: Single sys_clk domain, flags from comparators are async
// Notes: Thresholds live in analog; logic sees qualified flags
//
// Behaviour
// - Two identical channels: core rail and northbridge rail.
// - Warning flag on a channel drives thermal alert low.
// - Up/down fault counter; fault after 100 us accumulated warning.
// - Release level is 20 mV above trip level.
// - While alerted, alert release compares against reset level; fault counters still use trip.
// - Alert released only when both channels above reset level.
// - Shutdown flag immediately enters shutdown and records fault.
// - Fault drives power good low and tri-states drives.
// - Shutdown on one rail shuts down the other.
// - Faults clear only by enable low, supply good low or power-on reset.
// - Enable and supply good: clear faults, request soft-start.
`default_nettype none
module tfs_supervisor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire tfs_pkg::tfs_flags_s core_flags,
  input wire tfs_pkg::tfs_flags_s nb_temp_sense,
  input wire logic enable,
  input wire logic supply_ok,
  output logic thermal_alert_n,
  output logic thermal_alert_n_oe,
  output logic power_good,
  output logic drive_tristate,
  output logic soft_start,
  output logic [1:0] fault_src
);
  import tfs_pkg::*;
  // ==========================================
  // Input synchronisers
  tfs_flags_s [NUM_CH-1:0] meta;
  tfs_flags_s [NUM_CH-1:0] flg;
  logic [1:0] en_meta;
  logic [1:0] en_sync;
  logic ena;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      flg <= '0;
      en_meta <= 2'h0;
      en_sync <= 2'h0;
    end else begin
      meta <= {nb_temp_sense, core_flags};
      flg <= meta;
      en_meta <= {supply_ok, enable};
      en_sync <= en_meta;
    end
  end
  assign ena = en_sync[0] & en_sync[1];

  // ==========================================
  // Tick divider
  logic [DIV_W-1:0] div;
  logic tick;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= '0;
    end else if (tick) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end
  assign tick = (div == DIV_W'(TICK_CYCLES - 1));

  // ==========================================
  // State
  tfs_state_e state;
  tfs_state_e next_state;
  logic alert;
  logic [NUM_CH-1:0] cnt_full;
  logic [NUM_CH-1:0] shdn_hit;
  logic [NUM_CH-1:0] ch_fault;

  always_comb begin
    next_state = state;
    case (state)
      TFS_OFF: begin
        if (ena) begin
          next_state = TFS_RUN;
        end
      end
      TFS_RUN: begin
        if (!ena) begin
          next_state = TFS_OFF;
        end else if (|ch_fault) begin
          next_state = TFS_FAULT;
        end
      end
      TFS_FAULT: begin
        if (!ena) begin
          next_state = TFS_OFF;
        end
      end
      default: next_state = TFS_OFF;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TFS_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================
  // Per-channel counters
  logic [CNT_W-1:0] cnt [NUM_CH];

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt[c] <= '0;
      end else if (state != TFS_RUN) begin
        cnt[c] <= '0;
      end else if (tick) begin
        if (flg[c].warn && !cnt_full[c]) begin
          cnt[c] <= cnt[c] + 1'b1;
        end else if (!flg[c].warn && cnt[c] != '0) begin
          cnt[c] <= cnt[c] - 1'b1;
        end
      end
    end
    assign cnt_full[c] = (cnt[c] == CNT_W'(FAULT_TICKS));
    assign shdn_hit[c] = flg[c].shdn;
    assign ch_fault[c] = cnt_full[c] | shdn_hit[c];
  end

  // ==========================================
  // Alert and fault source
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alert <= 1'b0;
    end else if (!alert) begin
      alert <= |{flg[1].warn, flg[0].warn};
    end else if (flg[0].rst_ok && flg[1].rst_ok) begin
      alert <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_src <= 2'h0;
    end else if (state == TFS_OFF) begin
      fault_src <= 2'h0;
    end else if (state == TFS_RUN && next_state == TFS_FAULT) begin
      fault_src <= ch_fault;
    end
  end

  // ==========================================
  // Outputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_good <= 1'b0;
      drive_tristate <= 1'b1;
      soft_start <= 1'b0;
    end else begin
      power_good <= (next_state == TFS_RUN);
      drive_tristate <= (next_state != TFS_RUN);
      soft_start <= (state == TFS_OFF) && (next_state == TFS_RUN);
    end
  end
  // Open drain: drive low while alerted
  assign thermal_alert_n = 1'b0;
  assign thermal_alert_n_oe = alert;

  // ==========================================
  // Assertions
  property p_alert_on_warn;
    @(posedge sys_clk) disable iff (!rst_n)
      (!alert && (flg[0].warn || flg[1].warn)) |=> thermal_alert_n_oe;
  endproperty
  a_alert_on_warn: assert property (p_alert_on_warn)
    else $error("alert not asserted on warning");

  property p_alert_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      (alert && !(flg[0].rst_ok && flg[1].rst_ok)) |=> alert;
  endproperty
  a_alert_hold: assert property (p_alert_hold)
    else $error("alert released early");

  property p_alert_rel;
    @(posedge sys_clk) disable iff (!rst_n)
      (alert && flg[0].rst_ok && flg[1].rst_ok) |=> !alert;
  endproperty
  a_alert_rel: assert property (p_alert_rel)
    else $error("alert not released");

  property p_shdn_fault;
    @(posedge sys_clk) disable iff (!rst_n)
      (state == TFS_RUN && ena && (flg[0].shdn || flg[1].shdn))
        |=> state == TFS_FAULT ##1 !power_good && drive_tristate;
  endproperty
  a_shdn_fault: assert property (p_shdn_fault)
    else $error("shutdown not entered");

  property p_pg_low;
    @(posedge sys_clk) disable iff (!rst_n)
      (state == TFS_FAULT) |=> !power_good;
  endproperty
  a_pg_low: assert property (p_pg_low)
    else $error("power good high during fault");

  property p_fault_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      (state == TFS_FAULT && ena) |=> state == TFS_FAULT;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault cleared without enable low");

  property p_cnt_fault;
    @(posedge sys_clk) disable iff (!rst_n)
      (state == TFS_RUN && ena && |cnt_full) |=> state == TFS_FAULT;
  endproperty
  a_cnt_fault: assert property (p_cnt_fault)
    else $error("counter fault missed");

  property p_both_src;
    @(posedge sys_clk) disable iff (!rst_n)
      (state == TFS_RUN && ena && ch_fault[1]) |=> drive_tristate[*2];
  endproperty
  a_both_src: assert property (p_both_src)
    else $error("other rail not shut down");

  property p_restart;
    @(posedge sys_clk) disable iff (!rst_n)
      (state == TFS_OFF && ena) |=> soft_start;
  endproperty
  a_restart: assert property (p_restart)
    else $error("soft start missing");

  c_alert: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(alert));
  c_cnt_fault: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state == TFS_RUN && |cnt_full);
  c_shdn: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state == TFS_RUN && |shdn_hit);
  c_recover: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state == TFS_FAULT ##[1:50] state == TFS_RUN);
endmodule : tfs_supervisor
`default_nettype wire

/* tb/tfs_host_model.sv */
// Purpose: Host side of the thermal alert line
// Assumes: Alert line has a board pull-up
// Notes: Throttle follows the alert level
`default_nettype none
module tfs_host_model (
  input wire logic sys_clk,
  input wire logic alert_n,
  input wire logic alert_oe,
  output wire logic alert_line,
  output logic throttle
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Open-drain line
  assign alert_line = alert_oe ? alert_n : 1'b1;
  always_ff @(posedge sys_clk) begin
    throttle <= ~alert_line;
  end
endmodule : tfs_host_model
`default_nettype wire

/* tb/tfs_supervisor_bench.sv */
// Purpose: Self-checking bench for the thermal supervisor
// Assumes: 100 MHz sys_clk, flags driven as comparator levels
// Notes: Output changes are matched against a queue of notes
`default_nettype none
module tfs_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tfs_pkg::*;
  // ==========================================
  // Signals
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic enable = 1'b0;
  logic supply_ok = 1'b1;
  tfs_flags_s core_flags = 3'h2;
  tfs_flags_s nb_flags = 3'h2;
  wire logic alert_n, alert_oe, alert_line, throttle;
  wire logic power_good, drive_tristate, soft_start;
  wire logic [1:0] fault_src;
  wire logic [5:0] obs;
  logic [5:0] prev = 6'h24;
  logic [5:0] exp_q[$];
  int mismatches = 0;
  int comparisons = 0;
  logic [1:0] shdn_ch;
  assign obs = {alert_line, soft_start, power_good, drive_tristate,
    fault_src};
  // ==========================================
  // Instances
  tfs_supervisor dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .core_flags(core_flags), .nb_temp_sense(nb_flags),
    .enable(enable), .supply_ok(supply_ok),
    .thermal_alert_n(alert_n), .thermal_alert_n_oe(alert_oe),
    .power_good(power_good), .drive_tristate(drive_tristate),
    .soft_start(soft_start), .fault_src(fault_src));
  tfs_host_model host_u (.sys_clk(sys_clk), .alert_n(alert_n),
    .alert_oe(alert_oe), .alert_line(alert_line), .throttle(throttle));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // ==========================================
  // Tasks
  task check(input string nm, input logic [5:0] e, input logic [5:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : check
  task give_verdict();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task note(input logic [5:0] v);
    exp_q.push_back(v);
  endtask : note
  task wait_pg(input logic v, input int bound);
    for (int i = 0; i < bound; i++) begin
      @(negedge sys_clk);
      if (power_good === v) begin
        @(posedge sys_clk);
        return;
      end
    end
    check("wait", {5'h00, v}, {5'h00, power_good});
    give_verdict();
  endtask : wait_pg
  // ==========================================
  // Output monitor
  always @(negedge sys_clk) begin
    if (rst_n === 1'b1 && obs !== prev) begin
      if (exp_q.size() == 0) begin
        check("outputs", prev, obs);
      end else begin
        check("outputs", exp_q.pop_front(), obs);
      end
    end
    prev = obs;
  end
  // ==========================================
  // Stimulus
  initial begin
    void'($urandom(32'hAA0794B2));
    cyc(6);
    check("reset", 6'h24, obs);
    rst_n <= 1'b1;
    cyc(5);
    note(6'h38);
    note(6'h28);
    enable <= 1'b1;
    cyc(10);
    note(6'h08);
    nb_flags <= 3'h0;
    core_flags <= 3'h4;
    cyc(200 + $urandom % 800);
    check("throttle", 6'h01, {5'h00, throttle});
    core_flags <= 3'h0;
    cyc(50);
    core_flags <= 3'h2;
    cyc(50);
    note(6'h28);
    nb_flags <= 3'h2;
    cyc(20);
    note(6'h08);
    nb_flags <= 3'h4;
    cyc(6000);
    nb_flags <= 3'h0;
    cyc(3000);
    nb_flags <= 3'h4;
    cyc(6500);
    check("power_good", 6'h01, {5'h00, power_good});
    note(6'h06);
    wait_pg(1'b0, 1000);
    note(6'h26);
    nb_flags <= 3'h2;
    cyc(100);
    note(6'h24);
    enable <= 1'b0;
    cyc(10);
    note(6'h38);
    note(6'h28);
    enable <= 1'b1;
    cyc(10);
    shdn_ch = 2'h1 << ($urandom % 2);
    note({4'h1, shdn_ch});
    note({4'h9, shdn_ch});
    if (shdn_ch[1]) begin
      nb_flags <= 3'h5;
    end else begin
      core_flags <= 3'h5;
    end
    cyc(3);
    core_flags <= 3'h2;
    nb_flags <= 3'h2;
    wait_pg(1'b0, 3);
    note(6'h24);
    supply_ok <= 1'b0;
    cyc(10);
    note(6'h38);
    note(6'h28);
    supply_ok <= 1'b1;
    cyc(10);
    check("queue", 6'h00, 6'(exp_q.size()));
    give_verdict();
  end
endmodule : tfs_supervisor_bench
`default_nettype wire
